// >>> core/mcs_carrier_select.sv
// Carrier selection, polarity, pin release and carrier sync of a modulator.
// Assumes pin and peripheral inputs are asynchronous to clock.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "mcs_params.svh"

module mcs_carrier_select #(
    parameter int ADDR_W = 2
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_write_data,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_read_data,
    input wire logic carrier_input_pin_one,
    input wire logic carrier_input_pin_two,
    input wire logic reference_clock_in,
    input wire logic pwm_unit_one,
    input wire logic pwm_unit_two,
    input wire logic pwm_unit_three,
    input wire logic pwm_unit_four,
    input wire logic modulation_pin,
    output logic modulated_out,
    output logic modulator_enable,
    output logic [6:0] source_pin_release
);

    // ==========================================================
    // Elaboration checks
    if (ADDR_W < 2)
    begin : gen_bad_addr
        $error("ADDR_W must be at least 2");
    end

    // ==========================================================
    // Functions
    function automatic logic pick_source(input logic [3:0] sel, input logic [7:0] srcs);
        logic bit_value;
        bit_value = 1'b0;
        if (sel < `MCS_SEL_FIRST_RESERVED)
        begin
            bit_value = srcs[sel[2:0]];
        end
        return bit_value;
    endfunction : pick_source

    function automatic logic [6:0] release_for(input logic [7:0] ctrl);
        logic [6:0] rel;
        rel = '0;
        if (ctrl[`MCS_CAR_PIN_DISABLE] && ctrl[3:0] >= `MCS_SEL_PIN_ONE
            && ctrl[3:0] <= `MCS_SEL_PWM_FOUR)
        begin
            rel[ctrl[2:0] - 3'h1] = 1'b1;
        end
        return rel;
    endfunction : release_for

    function automatic logic [7:0] addr_hit(input logic [ADDR_W-1:0] addr);
        logic [7:0] hit;
        hit = '0;
        // Indexes above the four registers stay unmapped
        if ((addr >> 2) == '0)
        begin
            hit[addr[1:0]] = 1'b1;
        end
        return hit;
    endfunction : addr_hit

    // ==========================================================
    // State
    mcs_pkg::mcs_state_t s;
    mcs_pkg::mcs_state_t next_s;
    logic [7:0] sources;
    logic high_carrier;
    logic low_carrier;
    logic fall_high;
    logic fall_low;
    logic want_high;
    logic high_sync;
    logic low_sync;
    logic [7:0] hit;

    always_comb
    begin
        next_s = s;
        hit = addr_hit(reg_addr);
        // Source index 0 is ground
        sources = {s.sync_b[6:0], 1'b0};
        high_carrier = pick_source(s.high_ctrl[3:0], sources)
            ^ s.high_ctrl[`MCS_CAR_INVERT];
        low_carrier = pick_source(s.low_ctrl[3:0], sources)
            ^ s.low_ctrl[`MCS_CAR_INVERT];
        fall_high = s.prev_high && !high_carrier;
        fall_low = s.prev_low && !low_carrier;
        high_sync = s.high_ctrl[`MCS_CAR_SYNC];
        low_sync = s.low_ctrl[`MCS_CAR_SYNC];
        if (s.src_ctrl[3:0] == `MCS_SRC_SOFTWARE)
        begin
            want_high = s.mod_ctrl[`MCS_MOD_SW_VALUE];
        end
        else
        begin
            want_high = s.sync_b[7];
        end

        // Input synchronisers
        next_s.sync_a = {modulation_pin, pwm_unit_four, pwm_unit_three, pwm_unit_two,
            pwm_unit_one, reference_clock_in, carrier_input_pin_two,
            carrier_input_pin_one};
        next_s.sync_b = s.sync_a;
        next_s.prev_high = high_carrier;
        next_s.prev_low = low_carrier;

        // Carrier path switching
        case (s.side)
            mcs_pkg::MCS_HIGH_TIME:
            begin
                if (!want_high && (!high_sync || fall_high))
                begin
                    next_s.side = mcs_pkg::MCS_LOW_TIME;
                end
            end
            mcs_pkg::MCS_LOW_TIME:
            begin
                if (want_high && (!low_sync || fall_low))
                begin
                    next_s.side = mcs_pkg::MCS_HIGH_TIME;
                end
            end
            default:
            begin
                next_s.side = mcs_pkg::MCS_LOW_TIME;
            end
        endcase

        // Mixed output
        if (s.mod_ctrl[`MCS_MOD_ENABLE])
        begin
            next_s.out = ((next_s.side == mcs_pkg::MCS_HIGH_TIME) ? high_carrier
                : low_carrier) ^ s.mod_ctrl[`MCS_MOD_OUT_INVERT];
        end
        else
        begin
            next_s.out = 1'b0;
        end
        next_s.pin_release = release_for(s.high_ctrl) | release_for(s.low_ctrl);

        // Register writes
        if (reg_write && hit[`MCS_ADDR_HIGH_CARRIER])
        begin
            next_s.high_ctrl = reg_write_data & `MCS_CAR_WRITE_MASK;
        end
        if (reg_write && hit[`MCS_ADDR_LOW_CARRIER])
        begin
            next_s.low_ctrl = reg_write_data & `MCS_CAR_WRITE_MASK;
        end
        if (reg_write && hit[`MCS_ADDR_MOD_CONTROL])
        begin
            next_s.mod_ctrl = reg_write_data & `MCS_MOD_WRITE_MASK;
        end
        if (reg_write && hit[`MCS_ADDR_MOD_SOURCE])
        begin
            next_s.src_ctrl = reg_write_data & `MCS_SRC_WRITE_MASK;
        end

        // Register reads, data valid in the next cycle only
        next_s.read_data = '0;
        if (reg_read)
        begin
            case (1'b1)
                hit[`MCS_ADDR_HIGH_CARRIER]: next_s.read_data = s.high_ctrl;
                hit[`MCS_ADDR_LOW_CARRIER]: next_s.read_data = s.low_ctrl;
                hit[`MCS_ADDR_MOD_SOURCE]: next_s.read_data = s.src_ctrl;
                hit[`MCS_ADDR_MOD_CONTROL]:
                begin
                    next_s.read_data = s.mod_ctrl;
                    next_s.read_data[`MCS_MOD_STATUS] = s.out;
                end
                default: next_s.read_data = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s.high_ctrl <= `MCS_CAR_RESET;
            s.low_ctrl <= `MCS_CAR_RESET;
            s.mod_ctrl <= `MCS_MOD_RESET;
            s.src_ctrl <= `MCS_SRC_RESET;
            s.sync_a <= '0;
            s.sync_b <= '0;
            s.prev_high <= 1'b0;
            s.prev_low <= 1'b0;
            s.side <= mcs_pkg::MCS_LOW_TIME;
            s.out <= 1'b0;
            s.pin_release <= '0;
            s.read_data <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign reg_read_data = s.read_data;
    assign modulated_out = s.out;
    assign modulator_enable = s.mod_ctrl[`MCS_MOD_ENABLE];
    assign source_pin_release = s.pin_release;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    chk_high_pwm_release: assert property (
        s.high_ctrl[`MCS_CAR_PIN_DISABLE] && s.high_ctrl[3:0] == `MCS_SEL_PWM_ONE
        |=> source_pin_release[3])
        else $error("high pwm pin not released");
    chk_low_pwm_release: assert property (
        s.low_ctrl[`MCS_CAR_PIN_DISABLE] && s.low_ctrl[3:0] == `MCS_SEL_PWM_FOUR
        |=> source_pin_release[6])
        else $error("low pwm pin not released");
    chk_no_release: assert property (
        !s.high_ctrl[`MCS_CAR_PIN_DISABLE] && !s.low_ctrl[`MCS_CAR_PIN_DISABLE]
        |=> source_pin_release == 7'h00)
        else $error("pin released without disable");
    chk_disabled_silent: assert property (
        !modulator_enable |=> !modulated_out)
        else $error("output while disabled");
    chk_high_sync_hold: assert property (
        s.side == mcs_pkg::MCS_HIGH_TIME && high_sync && !fall_high
        |=> s.side == mcs_pkg::MCS_HIGH_TIME)
        else $error("high carrier left before falling edge");
    chk_high_nosync: assert property (
        s.side == mcs_pkg::MCS_HIGH_TIME && !high_sync && !want_high
        |=> s.side == mcs_pkg::MCS_LOW_TIME)
        else $error("high carrier not left at once");
    chk_low_sync_hold: assert property (
        s.side == mcs_pkg::MCS_LOW_TIME && low_sync && !fall_low
        |=> s.side == mcs_pkg::MCS_LOW_TIME)
        else $error("low carrier left before falling edge");
    chk_low_nosync: assert property (
        s.side == mcs_pkg::MCS_LOW_TIME && !low_sync && want_high
        |=> s.side == mcs_pkg::MCS_HIGH_TIME)
        else $error("low carrier not left at once");
    chk_reserved_none: assert property (
        s.high_ctrl[3:0] >= `MCS_SEL_FIRST_RESERVED
        |-> high_carrier == s.high_ctrl[`MCS_CAR_INVERT])
        else $error("reserved code carries a source");
    chk_pin_one_select: assert property (
        s.high_ctrl[3:0] == `MCS_SEL_PIN_ONE
        |-> high_carrier == (s.sync_b[0] ^ s.high_ctrl[`MCS_CAR_INVERT]))
        else $error("wrong high carrier source");
    chk_bit4_zero: assert property (
        reg_read && (hit[`MCS_ADDR_HIGH_CARRIER] || hit[`MCS_ADDR_LOW_CARRIER])
        |=> !reg_read_data[4])
        else $error("carrier bit 4 not zero");
    chk_write_readback: assert property (
        reg_write && hit[`MCS_ADDR_LOW_CARRIER] ##1 reg_read
        && hit[`MCS_ADDR_LOW_CARRIER] && !reg_write
        |=> reg_read_data == ($past(reg_write_data, 2) & `MCS_CAR_WRITE_MASK))
        else $error("carrier register readback wrong");
    chk_high_mix: assert property (
        modulator_enable && s.side == mcs_pkg::MCS_HIGH_TIME && want_high
        |=> modulated_out == $past(high_carrier ^ s.mod_ctrl[`MCS_MOD_OUT_INVERT]))
        else $error("high path not mixed");
    chk_low_mix: assert property (
        modulator_enable && s.side == mcs_pkg::MCS_LOW_TIME && !want_high
        |=> modulated_out == $past(low_carrier ^ s.mod_ctrl[`MCS_MOD_OUT_INVERT]))
        else $error("low path not mixed");

    cov_high_sync_wait: cover property (
        s.side == mcs_pkg::MCS_HIGH_TIME && high_sync && !want_high ##1
        s.side == mcs_pkg::MCS_HIGH_TIME ##1 s.side == mcs_pkg::MCS_LOW_TIME);
    cov_low_sync_wait: cover property (
        s.side == mcs_pkg::MCS_LOW_TIME && low_sync && want_high ##1
        s.side == mcs_pkg::MCS_LOW_TIME ##1 s.side == mcs_pkg::MCS_HIGH_TIME);
    cov_pin_released: cover property (source_pin_release != 7'h00);
    cov_output_toggles: cover property (modulator_enable && $rose(modulated_out));

endmodule : mcs_carrier_select

// >>> core/mcs_params.svh
// Constants of the modulator carrier select block.
// Assumes byte wide registers behind a plain strobe port.
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH

// ==========================================================
// Register indexes
`define MCS_ADDR_HIGH_CARRIER 2'h0
`define MCS_ADDR_LOW_CARRIER 2'h1
`define MCS_ADDR_MOD_CONTROL 2'h2
`define MCS_ADDR_MOD_SOURCE 2'h3

// ==========================================================
// Carrier control fields
`define MCS_CAR_PIN_DISABLE 7
`define MCS_CAR_INVERT 6
`define MCS_CAR_SYNC 5
`define MCS_CAR_WRITE_MASK 8'hEF
`define MCS_CAR_RESET 8'h00
`define MCS_SEL_PIN_ONE 4'h1
`define MCS_SEL_PWM_ONE 4'h4
`define MCS_SEL_PWM_FOUR 4'h7
`define MCS_SEL_FIRST_RESERVED 4'h8

// ==========================================================
// Modulator control and source fields
`define MCS_MOD_ENABLE 7
`define MCS_MOD_OUT_INVERT 4
`define MCS_MOD_STATUS 3
`define MCS_MOD_SW_VALUE 0
`define MCS_MOD_WRITE_MASK 8'hF1
`define MCS_MOD_RESET 8'h20
`define MCS_SRC_WRITE_MASK 8'h8F
`define MCS_SRC_RESET 8'h00
`define MCS_SRC_SOFTWARE 4'h0

`endif

// >>> core/mcs_pkg.sv
// Types of the modulator carrier select block.
// Assumes mcs_params.svh is on the include path.
`include "mcs_params.svh"

package mcs_pkg;

    // Which carrier path is being mixed
    typedef enum logic {MCS_HIGH_TIME, MCS_LOW_TIME} mcs_side_t;

    typedef struct packed {
        logic [7:0] high_ctrl;
        logic [7:0] low_ctrl;
        logic [7:0] mod_ctrl;
        logic [7:0] src_ctrl;
        logic [7:0] sync_a;
        logic [7:0] sync_b;
        logic prev_high;
        logic prev_low;
        mcs_side_t side;
        logic out;
        logic [6:0] pin_release;
        logic [7:0] read_data;
    } mcs_state_t;

endpackage : mcs_pkg

// >>> test/mcs_source_model.sv
// Behavioural carrier sources: two pins, reference clock, four PWM outputs.
// Assumes the bench sets the level that each source shows.
`timescale 1ns/1ns

module mcs_source_model (
    input wire logic [6:0] level,
    input wire logic [6:0] source_pin_release,
    output logic [6:0] carrier,
    output logic [6:0] pin_driven
);
    assign carrier = level;
    // Released source stops driving its own pin
    assign pin_driven = level & ~source_pin_release;
endmodule : mcs_source_model

// >>> test/tb_mcs_carrier_select.sv
// Self-checking bench of the modulator carrier select block.
// Assumes register indexes and reset values of mcs_params.svh.
`timescale 1ns/1ns
`include "mcs_params.svh"

module tb_mcs_carrier_select;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_write_data = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_read_data;
    logic [6:0] level = 7'h00;
    logic [6:0] src;
    logic modulation_pin = 1'b0;
    logic modulated_out;
    logic modulator_enable;
    logic [6:0] source_pin_release;
    logic [6:0] pin_driven;
    int miscompares = 0;
    int n_checks = 0;

    mcs_carrier_select u_mcs_carrier_select (.clock(clock), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_write_data(reg_write_data), .reg_write(reg_write),
        .reg_read(reg_read), .reg_read_data(reg_read_data),
        .carrier_input_pin_one(src[0]), .carrier_input_pin_two(src[1]),
        .reference_clock_in(src[2]), .pwm_unit_one(src[3]), .pwm_unit_two(src[4]),
        .pwm_unit_three(src[5]), .pwm_unit_four(src[6]),
        .modulation_pin(modulation_pin), .modulated_out(modulated_out),
        .modulator_enable(modulator_enable), .source_pin_release(source_pin_release));

    mcs_source_model u_mcs_source_model (.level(level),
        .source_pin_release(source_pin_release), .carrier(src), .pin_driven(pin_driven));

    // ==========================================================
    // Bus and compare tasks
    initial
    begin
        forever #5 clock = ~clock;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_write_data <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        d = reg_read_data;
    endtask : rd

    // Write followed by a read with no gap between the strobes
    task automatic wr_rd(input logic [1:0] a, input logic [7:0] dw, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_write_data <= dw;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        d = reg_read_data;
    endtask : wr_rd

    task automatic settle;
        repeat (6) @(posedge clock);
        #1;
    endtask : settle

    // ==========================================================
    // Scenarios
    task automatic reset_values;
        logic [7:0] d;
        logic [7:0] exp [4] = '{8'h00, 8'h00, 8'h20, 8'h00};
        for (int a = 0; a < 4; a++)
        begin
            rd(2'(a), d);
            chk(d, exp[a]);
        end
        chk({7'h00, modulator_enable}, 8'h00);
    endtask : reset_values

    task automatic reg_mask;
        logic [7:0] d;
        wr(2'h0, 8'hFF);
        wr(2'h1, 8'hFF);
        rd(2'h0, d);
        chk(d, 8'hEF);
        rd(2'h1, d);
        chk(d, 8'hEF);
        wr(2'h1, 8'h00);
        rd(2'h1, d);
        chk(d, 8'h00);
        wr_rd(2'h1, 8'h5A, d);
        chk(d, 8'h4A);
    endtask : reg_mask

    task automatic pin_release;
        logic [6:0] exp;
        level <= 7'h7F;
        for (int s = 0; s < 2; s++)
        begin
            for (int c = 0; c < 16; c++)
            begin
                wr(2'(s), 8'h80 | 8'(c));
                wr(2'(1 - s), 8'h00);
                exp = (c >= 1 && c <= 7) ? 7'(1 << (c - 1)) : 7'h00;
                settle();
                chk({1'b0, source_pin_release}, {1'b0, exp});
                chk({1'b0, pin_driven}, {1'b0, ~exp});
            end
        end
    endtask : pin_release

    task automatic select_mix;
        logic e;
        for (int s = 0; s < 2; s++)
            for (int p = 0; p < 2; p++)
                for (int c = 0; c < 9; c++)
                    for (int v = 0; v < 2; v++)
                    begin
                        level <= p ? 7'h2A : 7'h55;
                        wr(2'(s), 8'(v << 6) | 8'(c));
                        wr(2'(1 - s), 8'h00);
                        wr(2'h2, s ? 8'h80 : 8'h81);
                        settle();
                        e = (c >= 1 && c <= 7) ? level[c - 1] : 1'b0;
                        chk({7'h00, modulated_out}, {7'h00, e ^ v[0]});
                    end
    endtask : select_mix

    task automatic sync_hold;
        for (int s = 0; s < 2; s++)
            for (int y = 0; y < 2; y++)
            begin
                level <= 7'h01;
                wr(2'(s), 8'(y << 5) | 8'h01);
                wr(2'(1 - s), 8'h00);
                wr(2'h2, s ? 8'h80 : 8'h81);
                settle();
                chk({7'h00, modulated_out}, 8'h01);
                wr(2'h2, s ? 8'h81 : 8'h80);
                settle();
                chk({7'h00, modulated_out}, 8'(y));
                level <= 7'h00;
                settle();
                chk({7'h00, modulated_out}, 8'h00);
            end
    endtask : sync_hold

    task automatic reset_again;
        logic [7:0] d;
        wr(2'h2, 8'h81);
        settle();
        chk({7'h00, modulator_enable}, 8'h01);
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        rd(2'h2, d);
        chk(d, 8'h20);
        chk({7'h00, modulator_enable, modulated_out}, 8'h00);
    endtask : reset_again

    // ==========================================================
    // Sequence and verdict
    task automatic conclude;
        if (miscompares == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    initial
    begin
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        reset_values();
        reg_mask();
        pin_release();
        select_mix();
        sync_hold();
        reset_again();
        conclude();
    end

    initial
    begin
        #200000;
        miscompares++;
        conclude();
    end
endmodule : tb_mcs_carrier_select
